// *** rtl/exec_pkg.sv ***
// Purpose: Shared constants and types for the six-instruction execution block
// Assumes: 8-bit data path, 10-bit program counter, 64 data registers
// Notes: Opcode codes are local to this block and chosen freely
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int ADDR_W = 6;
    localparam int REG_COUNT = 64;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 10'h001;
    localparam int TABLE_HIGH_POINTER_LO = 0;
    localparam int TABLE_HIGH_POINTER_HI = 1;
    localparam int CALL_CYCLES = 2;
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [2:0]
    {
        OP_NOP = 3'h0,
        OP_TEST_BIT_SKIP_IF_SET = 3'h1,
        OP_CALL_VIA_WORKING_REGISTER = 3'h2,
        OP_CLEAR_WORKING_REGISTER = 3'h3,
        OP_CLEAR_DATA_REGISTER = 3'h4,
        OP_COMPLEMENT_DATA_REGISTER = 3'h5,
        OP_CLEAR_WATCHDOG = 3'h6
    } opcode_t;

    // One decoded instruction as presented by the fetch stage
    typedef struct packed
    {
        opcode_t op;
        logic [ADDR_W-1:0] addr;
        logic [2:0] bit_sel;
        logic dest;
    } instr_t;

    // Return stack push request
    typedef struct packed
    {
        logic push;
        logic [PC_W-1:0] addr;
    } push_t;

    // Watchdog side effects
    typedef struct packed
    {
        logic clear_counter;
        logic clear_divider;
    } wdt_clr_t;
endpackage

// *** rtl/bit_skip_call_clear_exec.sv ***
// Purpose: Executes bit test and skip, computed call, clears, complement, watchdog clear
// Assumes: Instruction arrives decoded, one per cycle, from same-clock fetch logic
// Notes: Owns working register, program counter, zero flag, data register file
`timescale 1ns/10ps
module bit_skip_call_clear_exec
#(
    parameter int DATA_W = exec_pkg::DATA_W,
    parameter int PC_W = exec_pkg::PC_W,
    parameter int REG_COUNT = exec_pkg::REG_COUNT
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire exec_pkg::instr_t instr,
    input wire logic instr_valid,
    input wire logic [DATA_W-1:0] table_high_pointer,
    input wire logic divider_to_watchdog,
    output logic instr_ready,
    output logic discard_fetched,
    output logic [PC_W-1:0] pc,
    output logic [DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic timeout_status_n,
    output logic sleep_status_n,
    output exec_pkg::push_t stack_push,
    output exec_pkg::wdt_clr_t wdt_clear
);
    // Data register file, one byte per register address
    logic [DATA_W-1:0] data_regs [REG_COUNT];

    // High during the idle second slot of a skip or call
    logic busy;

    // Operand path
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] inverted;
    logic bit_set;

    // Accept strobe and per-instruction strobes
    logic take;
    logic do_skip_test;
    logic do_call;
    logic do_clear_wreg;
    logic do_clear_reg;
    logic do_complement;
    logic do_clear_wdt;
    logic skip_taken;

    // Addresses formed for a call
    logic [PC_W-1:0] call_target;
    logic [PC_W-1:0] return_addr;

    // Operand read from the addressed data register
    assign operand = data_regs[instr.addr];

    // Complement result, shared by both destinations
    assign inverted = ~operand;

    // Selected bit of the operand for the skip test
    assign bit_set = operand[instr.bit_sel];

    // Handshake: one instruction per free cycle
    // An instruction offered while busy has no effect at all
    assign take = instr_valid && !busy;
    assign instr_ready = !busy;

    // Instruction strobes, each high only on an accepted instruction
    assign do_skip_test = take && (instr.op == exec_pkg::OP_TEST_BIT_SKIP_IF_SET);
    assign do_call = take && (instr.op == exec_pkg::OP_CALL_VIA_WORKING_REGISTER);
    assign do_clear_wreg = take && (instr.op == exec_pkg::OP_CLEAR_WORKING_REGISTER);
    assign do_clear_reg = take && (instr.op == exec_pkg::OP_CLEAR_DATA_REGISTER);
    assign do_complement = take && (instr.op == exec_pkg::OP_COMPLEMENT_DATA_REGISTER);
    assign do_clear_wdt = take && (instr.op == exec_pkg::OP_CLEAR_WATCHDOG);

    // skip when set
    // A clear bit lets the fetched instruction run as usual
    assign skip_taken = do_skip_test && bit_set;

    // form call target
    // Pointer bits 1:0 land above the full working register
    assign call_target = {table_high_pointer[exec_pkg::TABLE_HIGH_POINTER_HI:exec_pkg::TABLE_HIGH_POINTER_LO], working_register};

    // return address
    // Address of the instruction after the call
    assign return_addr = pc + exec_pkg::PC_STEP;

    // Second cycle of a skip or call runs as an idle slot
    // The slot never extends, so busy lasts exactly one cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            busy <= 1'b0;
        else if (skip_taken)
            busy <= 1'b1;
        else if (do_call)
            busy <= 1'b1;
        else
            busy <= 1'b0;
    end

    // Tells fetch to drop the instruction already fetched
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            discard_fetched <= 1'b0;
        else
            discard_fetched <= skip_taken;
    end

    // Program counter
    // Loads the call target on a call, else advances once per accepted instruction; also advances once per idle slot
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pc <= exec_pkg::PC_RESET;
        else if (do_call)
            pc <= call_target;
        else if (take || busy)
            pc <= pc + exec_pkg::PC_STEP;
    end

    // Return stack push, one-cycle pulse with return address
    // The address field follows pc every cycle; only push qualifies it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            stack_push <= '0;
        else
        begin
            stack_push.push <= do_call;
            stack_push.addr <= return_addr;
        end
    end

    // Working register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            working_register <= exec_pkg::WREG_RESET;
        else if (do_clear_wreg)
            working_register <= exec_pkg::ZERO_BYTE;
        else if (do_complement && !instr.dest)
            working_register <= inverted;
    end

    // Data register file, no reset as in real storage
    // Software must clear a register before relying on its value
    always_ff @(posedge ref_clk)
    begin
        if (do_clear_reg)
            data_regs[instr.addr] <= exec_pkg::ZERO_BYTE;
        else if (do_complement && instr.dest)
            data_regs[instr.addr] <= inverted;
    end

    // Zero flag
    // Only the clears and the complement touch it here
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            zero_flag <= 1'b0;
        else if (take)
        begin
            case (instr.op)
                exec_pkg::OP_CLEAR_WORKING_REGISTER: zero_flag <= 1'b1;
                exec_pkg::OP_CLEAR_DATA_REGISTER: zero_flag <= 1'b1;
                exec_pkg::OP_COMPLEMENT_DATA_REGISTER: zero_flag <= (inverted == exec_pkg::ZERO_BYTE);
                default: zero_flag <= zero_flag;
            endcase
        end
    end

    // Watchdog clear strobes, one-cycle pulses to the timer logic
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            wdt_clear <= '0;
        else
        begin
            wdt_clear.clear_counter <= do_clear_wdt;
            // The divider is left alone while it serves the timer instead
            wdt_clear.clear_divider <= do_clear_wdt && divider_to_watchdog;
        end
    end

    // Active-low status bits, set again by a watchdog clear
    // Lowering them belongs to the timeout and sleep logic outside
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            timeout_status_n <= 1'b1;
            sleep_status_n <= 1'b1;
        end
        else if (do_clear_wdt)
        begin
            timeout_status_n <= 1'b1;
            sleep_status_n <= 1'b1;
        end
    end
endmodule

// *** testbench/bit_skip_call_clear_exec_asserts.sv ***
// Purpose: Port checks of the execution block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the block
`timescale 1ns/10ps
module bit_skip_call_clear_exec_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire exec_pkg::instr_t instr,
    input wire logic instr_valid,
    input wire logic [7:0] table_high_pointer,
    input wire logic divider_to_watchdog,
    input wire logic instr_ready,
    input wire logic discard_fetched,
    input wire logic [9:0] pc,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic timeout_status_n,
    input wire logic sleep_status_n,
    input wire exec_pkg::push_t stack_push,
    input wire exec_pkg::wdt_clr_t wdt_clear
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Instruction accepted at this edge
    wire take = instr_valid && instr_ready;
    sequence s_call; take && instr.op == exec_pkg::OP_CALL_VIA_WORKING_REGISTER; endsequence
    sequence s_wdt; take && instr.op == exec_pkg::OP_CLEAR_WATCHDOG; endsequence
    sequence s_comp_w; take && instr.op == exec_pkg::OP_COMPLEMENT_DATA_REGISTER && !instr.dest; endsequence
    property p_comp_zero; s_comp_w |=> zero_flag == (working_register == 8'h00); endproperty
    property p_skip; discard_fetched |-> !instr_ready ##1 instr_ready; endproperty
    property p_call;
        s_call |=> stack_push.push && stack_push.addr == $past(pc) + 10'h001 && !instr_ready ##1 instr_ready;
    endproperty
    property p_target; s_call |=> pc == {$past(table_high_pointer[1:0]), $past(working_register)}; endproperty
    property p_clear_working_register;
        take && instr.op == exec_pkg::OP_CLEAR_WORKING_REGISTER |=> working_register == 8'h00 && zero_flag;
    endproperty
    property p_wdt; s_wdt |=> wdt_clear.clear_counter && wdt_clear.clear_divider == $past(divider_to_watchdog); endproperty
    property p_stat; s_wdt |=> timeout_status_n && sleep_status_n && instr_ready; endproperty
    property p_clear_data_register; take && instr.op == exec_pkg::OP_CLEAR_DATA_REGISTER |=> zero_flag && instr_ready; endproperty
    property p_comp;
        take && instr.op == exec_pkg::OP_COMPLEMENT_DATA_REGISTER && instr.dest |=> $stable(working_register);
    endproperty
    a_skip: assert property (p_skip) else $error("skip slot wrong");
    a_call: assert property (p_call) else $error("call push wrong");
    a_target: assert property (p_target) else $error("call target wrong");
    a_clear_working_register: assert property (p_clear_working_register) else $error("clear working wrong");
    a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
    a_stat: assert property (p_stat) else $error("status bits wrong");
    a_clear_data_register: assert property (p_clear_data_register) else $error("clear register wrong");
    a_comp: assert property (p_comp) else $error("complement dest wrong");
    a_comp_zero: assert property (p_comp_zero) else $error("complement zero wrong");
endmodule
bind bit_skip_call_clear_exec bit_skip_call_clear_exec_asserts i_chk (.*);

// *** testbench/bit_skip_call_clear_exec_tb_top.sv ***
// Purpose: Self-checking bench of the execution block
// Assumes: Inputs change on the falling edge
// Notes: Data registers seen only through the complement and the bit skip test
`timescale 1ns/10ps
module bit_skip_call_clear_exec_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    exec_pkg::instr_t instr = '0;
    logic instr_valid = 1'b0;
    logic [7:0] table_high_pointer = 8'h00;
    logic divider_to_watchdog = 1'b0;
    logic instr_ready, discard_fetched, zero_flag, timeout_status_n, sleep_status_n;
    logic [9:0] pc, pc_old;
    logic [7:0] working_register;
    exec_pkg::push_t stack_push;
    exec_pkg::wdt_clr_t wdt_clear;
    int err_total = 0;
    int num_checks = 0;
    bit_skip_call_clear_exec i_bit_skip_call_clear_exec (.*);
    // Clock
    initial forever #5 ref_clk = ~ref_clk;
    task chk(input string n, input logic [9:0] s, input logic [9:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    task final_report();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One instruction, then an idle cycle
    task op(input exec_pkg::opcode_t o, input logic [5:0] a, input logic [2:0] b, input logic d);
        @(negedge ref_clk);
        pc_old = pc;
        instr = '{o, a, b, d};
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
    endtask
    task t_clear();
        op(exec_pkg::OP_CLEAR_DATA_REGISTER, 6'h3f, 3'h0, 1'b0);
        op(exec_pkg::OP_COMPLEMENT_DATA_REGISTER, 6'h3f, 3'h0, 1'b0);
        chk("wreg", working_register, 8'hff);
        chk("zero", zero_flag, 1'b0);
        op(exec_pkg::OP_CLEAR_DATA_REGISTER, 6'h00, 3'h0, 1'b0);
        chk("zero", zero_flag, 1'b1);
        op(exec_pkg::OP_COMPLEMENT_DATA_REGISTER, 6'h00, 3'h0, 1'b1);
        chk("zero", zero_flag, 1'b0);
        op(exec_pkg::OP_CLEAR_WORKING_REGISTER, 6'h00, 3'h0, 1'b0);
        chk("wreg", working_register, 8'h00);
        chk("zero", zero_flag, 1'b1);
        op(exec_pkg::OP_COMPLEMENT_DATA_REGISTER, 6'h3f, 3'h0, 1'b1);
        op(exec_pkg::OP_COMPLEMENT_DATA_REGISTER, 6'h00, 3'h0, 1'b0);
        chk("zero", zero_flag, 1'b1);
    endtask
    task t_skip_call();
        op(exec_pkg::OP_TEST_BIT_SKIP_IF_SET, 6'h00, 3'h7, 1'b0);
        chk("discard", discard_fetched, 1'b1);
        chk("ready", instr_ready, 1'b0);
        op(exec_pkg::OP_CLEAR_DATA_REGISTER, 6'h05, 3'h0, 1'b0);
        op(exec_pkg::OP_TEST_BIT_SKIP_IF_SET, 6'h05, 3'h3, 1'b0);
        chk("discard", discard_fetched, 1'b0);
        op(exec_pkg::OP_COMPLEMENT_DATA_REGISTER, 6'h05, 3'h0, 1'b0);
        table_high_pointer = 8'hfe;
        op(exec_pkg::OP_CALL_VIA_WORKING_REGISTER, 6'h00, 3'h0, 1'b0);
        chk("push", stack_push.push, 1'b1);
        chk("ret", stack_push.addr, pc_old + 10'h001);
        chk("ready", instr_ready, 1'b0);
        chk("pc", pc, 10'h2ff);
    endtask
    task t_wdt();
        for (int d = 0; d < 2; d++)
        begin
            divider_to_watchdog = d[0];
            op(exec_pkg::OP_CLEAR_WATCHDOG, 6'h00, 3'h0, 1'b0);
            chk("cnt", wdt_clear.clear_counter, 1'b1);
            chk("div", wdt_clear.clear_divider, d[0]);
            chk("to_n", timeout_status_n, 1'b1);
            chk("pd_n", sleep_status_n, 1'b1);
        end
    endtask
    // Reset, then the scenarios
    initial
    begin
        repeat (7) @(negedge ref_clk);
        rst_n = 1'b1;
        t_clear();
        t_skip_call();
        t_wdt();
        final_report();
    end
    // Watchdog against a hang
    initial
    begin
        #20000;
        err_total++;
        final_report();
    end
endmodule
